// file: shared/timer_cfg.svh
// constants for the shared timer counter core
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define TMR_CH_NUM 4
`define TMR_PSC_W 16
`define TMR_DT_W 8
`define TMR_WIDE_CNT_W 32
`define TMR_STD_CNT_W 16
`define TMR_PSC_RST 16'h0000
`define TMR_DT_RST 8'h00

`endif

// file: shared/timer_pkg.sv
// types shared by the timer counter core and its channels
`default_nettype none
package timer_pkg;
  // per channel function
  typedef enum logic [1:0] {
    CH_CAPTURE = 2'b00,
    CH_COMPARE = 2'b01,
    CH_PWM = 2'b10,
    CH_OFF = 2'b11
  } ch_mode_e;
  // external trigger use
  typedef enum logic [1:0] {
    TRIG_NONE = 2'b00,
    TRIG_START = 2'b01,
    TRIG_GATE = 2'b10,
    TRIG_RESET = 2'b11
  } trig_mode_e;
  // capture edge choice
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } edge_sel_e;
endpackage
`default_nettype wire

// file: sim/multi_channel_pwm_timer_family_bench.sv
// self-checking bench for the timer counter core
`default_nettype none
module multi_channel_pwm_timer_family_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  logic clk, rst, enable, count_down, center_align, single_pulse, encoder_mode, ext_trig, chain_src, sync_in;
  logic upd_flag_clr, compl_en, enc_go, enc_back, pulse_go, enc_a, enc_b, cap_pin, dir_down, update_flag;
  logic running, up_dir;
  logic [15:0] prescale, reload, count, c0, up_count;
  logic [7:0] dead_time;
  logic [3:0] ch_in, ch_out, ch_out_n, cap_evt, cmp_evt, up_out, up_out_n;
  trig_mode_e trig_mode;
  ch_mode_e ch_mode [4];
  edge_sel_e ch_edge [4];
  logic [15:0] ch_cmp [4];
  logic [15:0] ch_cap [4];
  int miscompares, comparisons, hp, hn, ne, hq, hz;
  // row: prescale, reload, down, center, clocks, count, flag
  typedef struct packed {
    logic [15:0] psc;
    logic [15:0] rl;
    logic dn;
    logic ca;
    logic [7:0] n;
    logic [15:0] cnt;
    logic flg;
  } row_s;
  row_s rows [5] = '{
    '{16'h0000, 16'h0002, 1'b0, 1'b0, 8'h04, 16'h0001, 1'b1},
    '{16'h0002, 16'h0009, 1'b0, 1'b0, 8'h09, 16'h0003, 1'b0},
    '{16'h0000, 16'h0003, 1'b0, 1'b1, 8'h06, 16'h0000, 1'b1},
    '{16'h0001, 16'h0003, 1'b0, 1'b0, 8'h08, 16'h0000, 1'b1},
    '{16'h0000, 16'h0005, 1'b1, 1'b0, 8'h03, 16'h0003, 1'b1}
  };
  assign ch_in = {cap_pin, 1'b0, cap_pin, 1'b0}; // capture pin on channels 1 and 3
  timer_core dut_u (.clk, .rst, .enable, .prescale, .reload, .count_down, .center_align, .single_pulse,
    .encoder_mode, .enc_a, .enc_b, .trig_mode, .ext_trig, .chain_src, .sync_in, .upd_flag_clr, .compl_en,
    .dead_time, .ch_mode, .ch_edge, .ch_cmp, .ch_in, .count, .dir_down, .running, .update_pulse(),
    .update_flag, .trig_out(), .ch_out, .ch_out_n, .ch_cap, .cap_evt, .cmp_evt);
  // up-only build without dead time, sharing every input
  timer_core #(.UPDOWN(1'b0), .DEAD_EN(1'b0)) upcnt_u (.clk, .rst, .enable, .prescale, .reload, .count_down,
    .center_align, .single_pulse, .encoder_mode, .enc_a, .enc_b, .trig_mode, .ext_trig, .chain_src, .sync_in,
    .upd_flag_clr, .compl_en, .dead_time, .ch_mode, .ch_edge, .ch_cmp, .ch_in, .count(up_count),
    .dir_down(up_dir), .running(), .update_pulse(), .update_flag(), .trig_out(), .ch_out(up_out),
    .ch_out_n(up_out_n), .ch_cap(), .cap_evt(), .cmp_evt());
  timer_pins_model pins_u (.clk, .rst, .enc_go, .enc_back, .pulse_go, .enc_a, .enc_b, .cap_pin);
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // n edges, then settle
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // defaults and four clocks of reset
  task automatic apply_reset;
    if ($time > 0) @(posedge clk);
    rst <= 1'b1;
    {enable, count_down, center_align, single_pulse, encoder_mode, ext_trig} <= 6'h00;
    {chain_src, sync_in, upd_flag_clr, compl_en, enc_go, enc_back, pulse_go} <= 7'h00;
    prescale <= 16'h0000;
    reload <= 16'h0064;
    dead_time <= 8'h01;
    trig_mode <= TRIG_NONE;
    for (int k = 0; k < 4; k++) ch_mode[k] <= CH_OFF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
  initial begin
    miscompares = 0;
    comparisons = 0;
    for (int k = 0; k < 4; k++) begin
      ch_edge[k] = EDGE_BOTH;
      ch_cmp[k] = 16'h0000;
    end
    ch_edge[3] = EDGE_FALL;
    apply_reset;
    #1;
    check({count, update_flag, ch_out, ch_out_n}, 0);
    foreach (rows[i]) begin
      apply_reset;
      prescale <= rows[i].psc;
      reload <= rows[i].rl;
      count_down <= rows[i].dn;
      center_align <= rows[i].ca;
      enable <= 1'b1;
      wait_n(rows[i].n);
      check(count, rows[i].cnt);
      check(update_flag, rows[i].flg);
      if (rows[i].dn) check({up_dir, up_count}, 17'h00003);
    end
    // flag clear once stopped
    @(posedge clk);
    enable <= 1'b0;
    @(posedge clk);
    upd_flag_clr <= 1'b1;
    wait_n(1);
    check(update_flag, 0);
    // start trigger, then reset trigger
    apply_reset;
    trig_mode <= TRIG_START;
    enable <= 1'b1;
    wait_n(4);
    check(count, 0);
    check(running, 0);
    @(posedge clk);
    ext_trig <= 1'b1;
    wait_n(5);
    check(count != 16'h0000, 1);
    check(running, 1);
    @(posedge clk);
    trig_mode <= TRIG_RESET;
    ext_trig <= 1'b0;
    @(posedge clk);
    ext_trig <= 1'b1;
    wait_n(4);
    check(count < 16'h0005, 1);
    check(update_flag, 1);
    // gate trigger: count only while the trigger is high
    apply_reset;
    trig_mode <= TRIG_GATE;
    ext_trig <= 1'b1;
    enable <= 1'b1;
    wait_n(4);
    check(count, 4);
    ext_trig <= 1'b0;
    wait_n(4);
    check({running, count}, 4);
    // encoder forward eight edges, back three
    apply_reset;
    encoder_mode <= 1'b1;
    enable <= 1'b1;
    enc_go <= 1'b1;
    repeat (32) @(posedge clk);
    enc_go <= 1'b0;
    wait_n(6);
    check({dir_down, count}, 8);
    @(posedge clk);
    enc_back <= 1'b1;
    enc_go <= 1'b1;
    repeat (12) @(posedge clk);
    enc_go <= 1'b0;
    wait_n(6);
    check({dir_down, count}, 17'h10005);
    // chained counting on sync pulses
    apply_reset;
    chain_src <= 1'b1;
    enable <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      sync_in <= 1'b1;
      @(posedge clk);
      sync_in <= 1'b0;
    end
    wait_n(3);
    check(count, 3);
    // pwm pair with dead time, compare, capture
    apply_reset;
    reload <= 16'h0009;
    ch_mode[0] <= CH_PWM;
    ch_cmp[0] <= 16'h0004;
    ch_mode[1] <= CH_CAPTURE;
    ch_mode[2] <= CH_COMPARE;
    ch_mode[3] <= CH_CAPTURE;
    ch_cmp[2] <= 16'h0005;
    compl_en <= 1'b1;
    enable <= 1'b1;
    wait_n(30);
    hp = 0;
    hn = 0;
    ne = 0;
    hq = 0;
    hz = 0;
    repeat (100) begin
      wait_n(1);
      hp += ch_out[0];
      hn += ch_out_n[0];
      ne += cmp_evt[2];
      hq += up_out[0];
      hz += up_out_n[0];
    end
    check(hp, 20);
    check(hn, 40);
    check(ne, 10);
    check(hq, 40);
    check(hz, 0);
    @(posedge clk);
    reload <= 16'h00ff;
    pulse_go <= 1'b1;
    @(posedge clk);
    pulse_go <= 1'b0;
    ne = 0;
    c0 = 16'h0000;
    hn = 0;
    repeat (30) begin
      wait_n(1);
      hn += cap_evt[3];
      if (cap_evt[1] === 1'b1) begin
        ne++;
        c0 = ch_cap[1] - c0;
      end
    end
    check(ne, 2);
    check(c0, 16'h000a);
    check(hn, 1);
    // single pulse stops after one update
    apply_reset;
    single_pulse <= 1'b1;
    reload <= 16'h0003;
    enable <= 1'b1;
    wait_n(12);
    check({update_flag, count}, 17'h10000);
    wait_n(3);
    check({running, count}, 0);
    finish_test;
  end
endmodule
`default_nettype wire

// file: sim/timer_pins_model.sv
// pin side model: quadrature encoder and one capture pulse
`default_nettype none
module timer_pins_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic enc_go,
  input wire logic enc_back,
  input wire logic pulse_go,
  output logic enc_a,
  output logic enc_b,
  output logic cap_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase_reg; // quadrature phase
  logic [1:0] tick_reg; // clocks between steps
  logic [3:0] width_reg; // pulse clocks left
  // gray code, a leads b going forward
  assign enc_a = phase_reg[1] ^ phase_reg[0];
  assign enc_b = phase_reg[1];
  assign cap_pin = width_reg != 4'h0;
  // phase step every four clocks, pulse of ten clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= 2'h0;
      tick_reg <= 2'h0;
      width_reg <= 4'h0;
    end else begin
      if (enc_go) tick_reg <= tick_reg + 2'h1;
      if (enc_go && tick_reg == 2'h3) phase_reg <= enc_back ? phase_reg - 2'h1 : phase_reg + 2'h1;
      if (pulse_go) width_reg <= 4'ha;
      else if (width_reg != 4'h0) width_reg <= width_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: sim/timer_props.sv
// concurrent checks on the timer core ports
`default_nettype none
module timer_props #(parameter int CNT_W = 16, parameter int CH_NUM = 4, parameter bit UPDOWN = 1'b1,
  parameter bit DEAD_EN = 1'b1) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [15:0] prescale,
  input wire logic [CNT_W-1:0] reload,
  input wire logic count_down,
  input wire logic center_align,
  input wire logic single_pulse,
  input wire logic encoder_mode,
  input wire timer_pkg::trig_mode_e trig_mode,
  input wire logic ext_trig,
  input wire logic chain_src,
  input wire logic upd_flag_clr,
  input wire logic compl_en,
  input wire logic [7:0] dead_time,
  input wire logic [CNT_W-1:0] count,
  input wire logic update_pulse,
  input wire logic update_flag,
  input wire logic trig_out,
  input wire logic [CH_NUM-1:0] ch_out,
  input wire logic [CH_NUM-1:0] ch_out_n
);
  import timer_pkg::*;
  wire plain; // edge mode, one step every clock
  assign plain = enable && !encoder_mode && !chain_src && !center_align && !single_pulse
    && trig_mode == TRIG_NONE && prescale == 16'h0000;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // counting up below the reload value
  // up-only builds count up even when down is asked for
  up_step_a: assert property (plain && (!count_down || !UPDOWN) && count < reload
    |=> count == $past(count) + 1'b1)
    else $error("up step wrong");
  // up wrap to zero, update pulse on the same clock
  up_wrap_a: assert property (plain && !count_down && count == reload |=> count == 0 && update_pulse)
    else $error("up wrap wrong");
  // down wrap to reload value, update pulse on the same clock
  down_wrap_a: assert property (UPDOWN && plain && count_down && count == 0
    |=> count == reload && update_pulse)
    else $error("down wrap wrong");
  flag_set_a: assert property (update_pulse |-> update_flag)
    else $error("flag not set");
  flag_hold_a: assert property (update_flag && !upd_flag_clr |=> update_flag)
    else $error("flag lost");
  flag_clear_a: assert property (upd_flag_clr |=> !update_flag || update_pulse)
    else $error("flag not cleared");
  trig_same_a: assert property (trig_out == update_pulse)
    else $error("chain pulse wrong");
  // stopped or gated counter holds its value
  count_stall_a: assert property ((!enable && trig_mode != TRIG_RESET || trig_mode == TRIG_GATE && !ext_trig)
    |=> $stable(count))
    else $error("count moved");
  no_overlap_a: assert property (compl_en |-> (ch_out & ch_out_n) == '0)
    else $error("pair overlap");
  // gap of dead_time+1 clocks before the partner output rises
  dead_gap_a: assert property (DEAD_EN && $fell(ch_out[0]) && compl_en && dead_time == 8'h01
    |-> (!ch_out_n[0]) [*2] ##1 ch_out_n[0])
    else $error("dead gap wrong");
  cover property (update_pulse && count_down);
  cover property ($rose(ch_out_n[0]));
  cover property (encoder_mode && enable && $changed(count));
endmodule
bind timer_core timer_props #(.CNT_W(CNT_W), .CH_NUM(CH_NUM), .UPDOWN(UPDOWN), .DEAD_EN(DEAD_EN))
  props_u (.clk, .rst, .enable, .prescale, .reload,
  .count_down, .center_align, .single_pulse, .encoder_mode, .trig_mode, .ext_trig, .chain_src, .upd_flag_clr,
  .compl_en, .dead_time, .count, .update_pulse, .update_flag, .trig_out, .ch_out, .ch_out_n);
`default_nettype wire

// file: src/timer_channel.sv
// one capture / compare / pwm channel with dead-time output pair
`default_nettype none
`include "timer_cfg.svh"
module timer_channel #(
  parameter int CNT_W = 16,
  parameter int DT_W = `TMR_DT_W,
  parameter bit DEAD_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cnt_new,
  input wire logic [CNT_W-1:0] cnt,
  input wire logic [CNT_W-1:0] cmp,
  input wire timer_pkg::ch_mode_e mode,
  input wire timer_pkg::edge_sel_e edge_sel,
  input wire logic pin_in,
  input wire logic compl_en,
  input wire logic [DT_W-1:0] dead_time,
  output logic out_p,
  output logic out_n,
  output logic [CNT_W-1:0] cap_val,
  output logic cap_evt,
  output logic cmp_evt
);
  import timer_pkg::*;

  logic pin_d_reg; // previous pin level
  logic ref_reg; // reference waveform
  logic ref_d_reg; // reference seen last cycle
  logic [DT_W-1:0] dt_reg; // dead-time countdown
  logic [CNT_W-1:0] cap_reg; // captured count
  logic cap_evt_reg;
  logic cmp_evt_reg;
  logic p_reg;
  logic n_reg;

  // edge and match decode
  wire rise = pin_in & ~pin_d_reg;
  wire fall = ~pin_in & pin_d_reg;
  wire cap_hit = (mode == CH_CAPTURE) &&
                 ((edge_sel == EDGE_RISE && rise) || (edge_sel == EDGE_FALL && fall) ||
                  (edge_sel == EDGE_BOTH && (rise | fall)));
  wire match = cnt_new && (cnt == cmp);
  wire pwm_ref = cnt < cmp;
  wire ref_next = (mode == CH_PWM) ? pwm_ref :
                  (mode == CH_COMPARE && match) ? ~ref_reg :
                  (mode == CH_COMPARE) ? ref_reg : 1'b0;
  wire ref_chg = ref_reg != ref_d_reg;

  // capture, compare and reference waveform
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_d_reg <= 1'b0;
      ref_reg <= 1'b0;
      ref_d_reg <= 1'b0;
      cap_reg <= '0;
      cap_evt_reg <= 1'b0;
      cmp_evt_reg <= 1'b0;
    end else begin
      pin_d_reg <= pin_in;
      ref_reg <= ref_next;
      ref_d_reg <= ref_reg;
      if (cap_hit) begin
        cap_reg <= cnt;
      end
      cap_evt_reg <= cap_hit;
      cmp_evt_reg <= match && (mode != CH_CAPTURE) && (mode != CH_OFF);
    end
  end

  // dead-time pair: both low for dead_time+1 cycles after each reference change
  always_ff @(posedge clk) begin
    if (rst) begin
      dt_reg <= '0;
      p_reg <= 1'b0;
      n_reg <= 1'b0;
    end else if (DEAD_EN && ref_chg) begin
      dt_reg <= dead_time;
      p_reg <= 1'b0;
      n_reg <= 1'b0;
    end else if (DEAD_EN && dt_reg != '0) begin
      dt_reg <= dt_reg - 1'b1;
    end else begin
      p_reg <= ref_reg;
      n_reg <= DEAD_EN && compl_en && (mode != CH_CAPTURE) && (mode != CH_OFF) && ~ref_reg;
    end
  end

  assign out_p = p_reg;
  assign out_n = n_reg;
  assign cap_val = cap_reg;
  assign cap_evt = cap_evt_reg;
  assign cmp_evt = cmp_evt_reg;
endmodule
`default_nettype wire

// file: src/timer_core.sv
// shared timer counter core: prescaler, counter, trigger, encoder, four channels
`default_nettype none
`include "timer_cfg.svh"
// How it works
// - four channels: pwm, compare or capture
// - external trigger starts, gates or resets counting
// - advanced build drives eight outputs, four p/n pairs
// - complementary pairs with programmable dead time
// - capture, compare, edge/center pwm, single pulse
// - advanced build reuses this same core
// - sync input chains other timers' updates
// - capture pulse widths, make pulses and pwm
// - wide build: 32-bit up/down, 16-bit prescaler
// - second build: 16-bit up/down counter
// - remaining builds: 16-bit up-only counter
// - quadrature encoder steps counter, sets direction
module timer_core #(
  parameter int CNT_W = `TMR_STD_CNT_W,
  parameter bit UPDOWN = 1'b1,
  parameter bit DEAD_EN = 1'b1,
  parameter int CH_NUM = `TMR_CH_NUM,
  parameter int PSC_W = `TMR_PSC_W,
  parameter int DT_W = `TMR_DT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [PSC_W-1:0] prescale,
  input wire logic [CNT_W-1:0] reload,
  input wire logic count_down,
  input wire logic center_align,
  input wire logic single_pulse,
  input wire logic encoder_mode,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire timer_pkg::trig_mode_e trig_mode,
  input wire logic ext_trig,
  input wire logic chain_src,
  input wire logic sync_in,
  input wire logic upd_flag_clr,
  input wire logic compl_en,
  input wire logic [DT_W-1:0] dead_time,
  input wire timer_pkg::ch_mode_e ch_mode [CH_NUM],
  input wire timer_pkg::edge_sel_e ch_edge [CH_NUM],
  input wire logic [CNT_W-1:0] ch_cmp [CH_NUM],
  input wire logic [CH_NUM-1:0] ch_in,
  output logic [CNT_W-1:0] count,
  output logic dir_down,
  output logic running,
  output logic update_pulse,
  output logic update_flag,
  output logic trig_out,
  output logic [CH_NUM-1:0] ch_out,
  output logic [CH_NUM-1:0] ch_out_n,
  output logic [CNT_W-1:0] ch_cap [CH_NUM],
  output logic [CH_NUM-1:0] cap_evt,
  output logic [CH_NUM-1:0] cmp_evt
);
  import timer_pkg::*;

  // state
  logic [PSC_W-1:0] psc_reg; // prescaler counter
  logic [CNT_W-1:0] cnt_reg; // main counter
  logic [CNT_W-1:0] cnt_next;
  logic dir_reg; // 1 while counting down
  logic dir_next;
  logic upd_next; // reload happens this cycle
  logic trig_d_reg; // previous trigger level
  logic started_reg; // start trigger seen
  logic sp_done_reg; // single pulse finished
  logic a_d_reg; // previous encoder a
  logic b_d_reg; // previous encoder b
  logic upd_reg; // one-cycle update pulse
  logic upd_flag_reg; // sticky update flag
  logic trig_out_reg; // chaining pulse out
  logic cnt_new_reg; // counter moved last cycle
  logic run_reg; // counting enabled, registered

  // trigger decode
  wire trig_rise = ext_trig & ~trig_d_reg;
  wire trig_start_ok = (trig_mode != TRIG_START) || started_reg;
  wire trig_gate_ok = (trig_mode != TRIG_GATE) || ext_trig;
  wire trig_reset = (trig_mode == TRIG_RESET) && trig_rise && enable;
  wire active = enable && trig_start_ok && trig_gate_ok && !sp_done_reg;

  // prescaler decode
  wire psc_hit = psc_reg >= prescale;
  wire psc_tick = active && !encoder_mode && !chain_src && psc_hit;

  // quadrature decode: one step per edge of either input
  wire a_chg = enc_a ^ a_d_reg;
  wire b_chg = enc_b ^ b_d_reg;
  wire enc_step = encoder_mode && (a_chg ^ b_chg);
  wire enc_up = enc_a ^ b_d_reg;

  // chained step from another timer's update
  wire chain_step = !encoder_mode && chain_src && sync_in;

  // one counter step this cycle
  wire step = active && (enc_step || chain_step || psc_tick);

  // direction for edge-aligned and encoder counting; up-only builds ignore down requests
  wire want_down = UPDOWN && (encoder_mode ? !enc_up : count_down);
  wire center = UPDOWN && center_align && !encoder_mode;

  // counter next value
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    upd_next = 1'b0;
    if (trig_reset) begin
      // restart from the start of the period
      cnt_next = want_down && !center ? reload : '0;
      dir_next = want_down && !center;
      upd_next = 1'b1;
    end else if (step && center) begin
      // center aligned: up to reload, down to zero, update at both ends
      if (!dir_reg && cnt_reg >= reload) begin
        cnt_next = (reload == '0) ? '0 : reload - 1'b1;
        dir_next = 1'b1;
        upd_next = 1'b1;
      end else if (dir_reg && cnt_reg == '0) begin
        cnt_next = (reload == '0) ? '0 : {{(CNT_W-1){1'b0}}, 1'b1};
        dir_next = 1'b0;
        upd_next = 1'b1;
      end else if (dir_reg) begin
        cnt_next = cnt_reg - 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end else if (step && want_down) begin
      // down counting: underflow reloads
      dir_next = 1'b1;
      if (cnt_reg == '0) begin
        cnt_next = reload;
        upd_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end else if (step) begin
      // up counting: overflow past reload wraps to zero
      dir_next = 1'b0;
      if (cnt_reg >= reload) begin
        cnt_next = '0;
        upd_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // prescaler divider: one count enable every prescale+1 cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      psc_reg <= PSC_W'(`TMR_PSC_RST);
    end else if (trig_reset || !active || encoder_mode || chain_src || psc_hit) begin
      psc_reg <= '0;
    end else begin
      psc_reg <= psc_reg + 1'b1;
    end
  end

  // counter and direction
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      dir_reg <= 1'b0;
      cnt_new_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      cnt_new_reg <= step || trig_reset;
    end
  end

  // trigger history and start latch
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_d_reg <= 1'b0;
      started_reg <= 1'b0;
    end else begin
      trig_d_reg <= ext_trig;
      if (!enable || trig_mode != TRIG_START) begin
        started_reg <= 1'b0;
      end else if (trig_rise) begin
        started_reg <= 1'b1;
      end
    end
  end

  // single pulse: stop at the first update not made by a reset trigger, rearm when disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_done_reg <= 1'b0;
    end else if (!enable) begin
      sp_done_reg <= 1'b0;
    end else if (single_pulse && upd_next && !trig_reset) begin
      sp_done_reg <= 1'b1;
    end
  end

  // encoder input history
  always_ff @(posedge clk) begin
    if (rst) begin
      a_d_reg <= 1'b0;
      b_d_reg <= 1'b0;
    end else begin
      a_d_reg <= enc_a;
      b_d_reg <= enc_b;
    end
  end

  // update event pulse, sticky flag (set wins over clear), chaining output
  always_ff @(posedge clk) begin
    if (rst) begin
      upd_reg <= 1'b0;
      upd_flag_reg <= 1'b0;
      trig_out_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      upd_reg <= upd_next;
      trig_out_reg <= upd_next;
      run_reg <= active;
      if (upd_next) begin
        upd_flag_reg <= 1'b1;
      end else if (upd_flag_clr) begin
        upd_flag_reg <= 1'b0;
      end
    end
  end

  // the same channels serve every build; the advanced one adds the n outputs
  generate
    for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
      timer_channel #(
        .CNT_W(CNT_W),
        .DT_W(DT_W),
        .DEAD_EN(DEAD_EN)
      ) u_ch (
        .clk(clk),
        .rst(rst),
        .cnt_new(cnt_new_reg),
        .cnt(cnt_reg),
        .cmp(ch_cmp[i]),
        .mode(ch_mode[i]),
        .edge_sel(ch_edge[i]),
        .pin_in(ch_in[i]),
        .compl_en(compl_en),
        .dead_time(dead_time),
        .out_p(ch_out[i]),
        .out_n(ch_out_n[i]),
        .cap_val(ch_cap[i]),
        .cap_evt(cap_evt[i]),
        .cmp_evt(cmp_evt[i])
      );
    end
  endgenerate

  // registered outputs
  assign count = cnt_reg;
  assign dir_down = dir_reg;
  assign running = run_reg;
  assign update_pulse = upd_reg;
  assign update_flag = upd_flag_reg;
  assign trig_out = trig_out_reg;
endmodule
`default_nettype wire
